// [dmc_ctrl.sv]
// ddr sdram command issuer: mode register programming, precharge, activate, read and write
// Summary of operation
// RULE1: mode write drives cs ras cas we ba0 low with opcode on address pins.
// RULE2: mode write only with all banks closed and cke high; emr first (not enforced: a mode write is accepted without a prior extended write).
// RULE3: mode write occupies two cycles; no other command meanwhile.
// RULE4: mode fields: length a0-a2, type a3, latency a4-a6, test a7, dll reset a8.
// RULE5: test mode bit a7 driven low on every mode write.
// RULE6: mode registers rewritten during operation only while all banks idle.
// RULE7: sequential bursts increment from start column, wrapping in aligned block.
// RULE8: interleave bursts xor start column with a counter.
// RULE9: mode write waits the precharge period after precharge.
// RULE10: extended mode write is the mode write with ba0 high.
// RULE11: extended register bit a0 enables or disables the dll.
// RULE12: extended write keeps all address pins except a0 and ba0 low.
// RULE13: extended write takes two cycles, all banks closed, cke high.
// RULE14: after dll enable, 200 cycles pass before any read.
// RULE15: dll re-enables itself on self refresh exit.
// RULE16: precharge is cs ras we low, cas high.
// RULE17: a10 high closes all banks; low selects one bank by ba.
// RULE18: write recovery time respected before precharging a written bank.
// RULE19: precharge period respected before reactivating the bank.
// RULE20: idle cycles drive nop; deselect ignored by device.
// RULE21: activate is cs ras low, cas we high, bank from ba.
// RULE22: bank activated first, activate-to-column delay before read or write.
// RULE23: bank closed before reactivation; activations spaced by bank-to-bank delay.
// RULE24: read length and latency follow the last mode write.
// RULE25: write length follows the last mode write.
// RULE26: read is cs cas low, ras we high.
// RULE27: write is cs cas we low, ras high.
// RULE28: mode codes follow the standard encoding for length, type and latency.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_params.svh"

module dmc_ctrl
   import dmc_pkg::*;
#(
   parameter int ROW_W = 13,
   parameter int TRP_CYC = `DMC_TRP_CYC,
   parameter int TRCD_CYC = `DMC_TRCD_CYC,
   parameter int TRRD_CYC = `DMC_TRRD_CYC,
   parameter int TWR_CYC = `DMC_TWR_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // user request
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic [1:0] req_bank,
   input wire logic [ROW_W-1:0] req_addr,
   input wire logic req_all_banks,
   output logic req_ready,
   output logic req_reject,
   // programmed mode and open banks seen by the user
   output logic [2:0] mode_burst_len,
   output logic mode_interleave,
   output logic [2:0] mode_cas_lat,
   output logic dll_enabled,
   output logic [3:0] bank_open,
   // device pins
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [ROW_W-1:0] addr
);

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   localparam logic [7:0] TMRD_GAP = 8'(`DMC_TMRD_CYC - 1);
   localparam logic [7:0] DLL_LOCK = 8'(`DMC_DLL_LOCK_CYC);

   function automatic logic [7:0] sat_dec(input logic [7:0] v);
      sat_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
   endfunction

   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      max8 = (a > b) ? a : b;
   endfunction

   dmc_op_t op;
   dmc_state_t state_reg, state_next;
   logic [7:0] gap_reg;
   logic [7:0] dll_cnt_reg;
   logic [7:0] rrd_reg;
   logic [7:0] bank_tmr_reg [4];
   logic [3:0] written_reg;
   logic [3:0] open_reg;
   logic dll_on_reg;
   logic ready_reg, reject_reg;
   logic [3:0] pins_reg;
   logic [1:0] ba_reg;
   logic [ROW_W-1:0] addr_reg;
   logic [2:0] bl_reg, cl_reg;
   logic bt_reg;

   assign op = dmc_op_t'(req_op);

   wire all_idle = (open_reg == 4'h0);
   wire bank_is_open = open_reg[req_bank];
   wire bank_tmr_done = (bank_tmr_reg[req_bank] == 8'h00);
   wire all_tmr_done = (bank_tmr_reg[0] == 8'h00) && (bank_tmr_reg[1] == 8'h00)
                       && (bank_tmr_reg[2] == 8'h00) && (bank_tmr_reg[3] == 8'h00);
   wire any_written = |(written_reg & open_reg);
   wire go = req_valid && (state_reg == DMC_ST_IDLE);

   // mode writes only when idle with every precharge period spent [RULE2] [RULE6] [RULE9] [RULE13]
   wire mode_ok = all_idle && all_tmr_done;
   // precharge waits write recovery of every bank it closes [RULE18]
   wire pre_ok = req_all_banks ? (all_tmr_done || !any_written) : bank_tmr_done;
   // activate only a closed bank past its precharge period, spaced by rrd [RULE19] [RULE23]
   wire act_ok = !bank_is_open && bank_tmr_done && (rrd_reg == 8'h00);
   // column command only after the activate-to-column delay [RULE22]
   wire col_ok = bank_is_open && bank_tmr_done;
   // no read until the dll has locked [RULE14]
   wire rd_ok = col_ok && dll_on_reg && (dll_cnt_reg == 8'h00);

   logic accept;
   always_comb
   begin
      unique case (op)
         DMC_OP_NOP: accept = 1'b1;
         DMC_OP_MRS: accept = mode_ok;
         DMC_OP_EMRS: accept = mode_ok;
         DMC_OP_PRE: accept = pre_ok;
         DMC_OP_ACT: accept = act_ok;
         DMC_OP_RD: accept = rd_ok;
         DMC_OP_WR: accept = col_ok;
         default: accept = 1'b0;
      endcase
   end

   wire take = go && accept;
   wire refuse = go && !accept;

   // ----------------------------------------
   // pin encoding
   // ----------------------------------------
   logic [3:0] pins_next;
   logic [1:0] ba_next;
   logic [ROW_W-1:0] addr_next;
   always_comb
   begin
      pins_next = `DMC_PIN_NOP;   // idle cycles are nop [RULE20]
      ba_next = 2'h0;
      addr_next = '0;
      if (take)
      begin
         unique case (op)
            DMC_OP_NOP:
            begin
               pins_next = `DMC_PIN_NOP;
            end
            DMC_OP_MRS:
            begin
               pins_next = `DMC_PIN_MRS;   // [RULE1]
               ba_next = 2'h0;
               addr_next = req_addr;   // fields per standard layout [RULE4] [RULE28]
               addr_next[`DMC_MR_TM_POS] = 1'b0;   // [RULE5]
            end
            DMC_OP_EMRS:
            begin
               pins_next = `DMC_PIN_MRS;
               ba_next = 2'h1;   // [RULE10]
               addr_next[`DMC_EMR_DLLDIS_POS] = req_addr[`DMC_EMR_DLLDIS_POS];   // [RULE11] [RULE12]
            end
            DMC_OP_PRE:
            begin
               pins_next = `DMC_PIN_PRE;   // [RULE16]
               ba_next = req_bank;
               addr_next[`DMC_AP_POS] = req_all_banks;   // [RULE17]
            end
            DMC_OP_ACT:
            begin
               pins_next = `DMC_PIN_ACT;   // [RULE21]
               ba_next = req_bank;
               addr_next = req_addr;
            end
            DMC_OP_RD:
            begin
               pins_next = `DMC_PIN_RD;   // [RULE26]
               ba_next = req_bank;
               addr_next = req_addr;
               addr_next[`DMC_AP_POS] = 1'b0;
            end
            DMC_OP_WR:
            begin
               pins_next = `DMC_PIN_WR;   // [RULE27]
               ba_next = req_bank;
               addr_next = req_addr;
               addr_next[`DMC_AP_POS] = 1'b0;
            end
            default:
            begin
               pins_next = `DMC_PIN_NOP;
            end
         endcase
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   // mode writes hold off every command for the second cycle [RULE3] [RULE13]
   wire is_mode = take && ((op == DMC_OP_MRS) || (op == DMC_OP_EMRS));
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         DMC_ST_IDLE: if (is_mode) state_next = DMC_ST_WAIT;
         DMC_ST_WAIT: if (gap_reg == 8'h00) state_next = DMC_ST_IDLE;
      endcase
   end

   wire [7:0] trp = 8'(TRP_CYC);
   wire [7:0] trcd = 8'(TRCD_CYC);
   wire [7:0] trrd = 8'(TRRD_CYC);
   wire [7:0] twr = 8'(TWR_CYC);
   wire pre_take = take && (op == DMC_OP_PRE);
   wire act_take = take && (op == DMC_OP_ACT);
   wire wr_take = take && (op == DMC_OP_WR);
   wire emrs_take = take && (op == DMC_OP_EMRS);
   wire mrs_take = take && (op == DMC_OP_MRS);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg <= DMC_ST_IDLE;
         gap_reg <= 8'h00;
         rrd_reg <= 8'h00;
         dll_cnt_reg <= 8'h00;
         dll_on_reg <= 1'b0;
         open_reg <= 4'h0;
         written_reg <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         gap_reg <= is_mode ? sat_dec(TMRD_GAP) : sat_dec(gap_reg);
         rrd_reg <= act_take ? sat_dec(trrd) : sat_dec(rrd_reg);
         if (emrs_take)
         begin
            dll_on_reg <= !req_addr[`DMC_EMR_DLLDIS_POS];
            dll_cnt_reg <= DLL_LOCK;   // lock window restarts on each dll enable [RULE14]
         end
         else
         begin
            dll_cnt_reg <= sat_dec(dll_cnt_reg);
         end
         if (act_take)
         begin
            open_reg[req_bank] <= 1'b1;
            written_reg[req_bank] <= 1'b0;
         end
         if (wr_take)
            written_reg[req_bank] <= 1'b1;
         if (pre_take)
         begin
            if (req_all_banks)
               open_reg <= 4'h0;
            else
               open_reg[req_bank] <= 1'b0;
         end
      end
   end

   // per bank timer: trcd after activate, twr after write, trp after precharge
   for (genvar b = 0; b < 4; b++)
   begin : g_bank
      wire hit = (req_bank == 2'(b)) || (pre_take && req_all_banks);
      always_ff @(posedge core_clk)
      begin
         if (rst)
            bank_tmr_reg[b] <= 8'h00;
         else if (hit && pre_take)
            bank_tmr_reg[b] <= max8(sat_dec(bank_tmr_reg[b]), sat_dec(trp));
         else if (hit && act_take)
            bank_tmr_reg[b] <= sat_dec(trcd);
         else if (hit && wr_take)
            bank_tmr_reg[b] <= twr;
         else
            bank_tmr_reg[b] <= sat_dec(bank_tmr_reg[b]);
      end
   end

   // the controller keeps a copy of the programmed mode for its user [RULE24] [RULE25]
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         bl_reg <= 3'h0;
         bt_reg <= 1'b0;
         cl_reg <= 3'h0;
      end
      else if (mrs_take)
      begin
         bl_reg <= req_addr[`DMC_MR_BL_LSB +: 3];
         bt_reg <= req_addr[`DMC_MR_BT_POS];   // sequential or interleave order [RULE7] [RULE8]
         cl_reg <= req_addr[`DMC_MR_CL_LSB +: 3];
      end
   end

   // ----------------------------------------
   // pin and status registers
   // ----------------------------------------
   // cke stays high after reset; power-down and self refresh are not issued here [RULE15]
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pins_reg <= `DMC_PIN_DESEL;
         ba_reg <= 2'h0;
         addr_reg <= '0;
         ready_reg <= 1'b0;
         reject_reg <= 1'b0;
         cke <= 1'b0;
      end
      else
      begin
         pins_reg <= pins_next;
         ba_reg <= ba_next;
         addr_reg <= addr_next;
         ready_reg <= take;
         reject_reg <= refuse;
         cke <= 1'b1;
      end
   end

   assign {cs_n, ras_n, cas_n, we_n} = pins_reg;
   assign ba = ba_reg;
   assign addr = addr_reg;
   assign req_ready = ready_reg;
   assign req_reject = reject_reg;
   assign mode_burst_len = bl_reg;
   assign mode_interleave = bt_reg;
   assign mode_cas_lat = cl_reg;
   assign dll_enabled = dll_on_reg;
   assign bank_open = open_reg;

endmodule
`default_nettype wire

// [dmc_params.svh]
// timing counts, field positions and command encodings for the ddr mode/command controller
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define DMC_CLK_PERIOD_NS 25
`define DMC_TMRD_CYC 2
`define DMC_DLL_LOCK_CYC 200
`define DMC_TRP_NS 20
`define DMC_TRCD_NS 20
`define DMC_TRRD_NS 15
`define DMC_TWR_NS 15
`define DMC_TRP_CYC ((`DMC_TRP_NS + `DMC_CLK_PERIOD_NS - 1) / `DMC_CLK_PERIOD_NS)
`define DMC_TRCD_CYC ((`DMC_TRCD_NS + `DMC_CLK_PERIOD_NS - 1) / `DMC_CLK_PERIOD_NS)
`define DMC_TRRD_CYC ((`DMC_TRRD_NS + `DMC_CLK_PERIOD_NS - 1) / `DMC_CLK_PERIOD_NS)
`define DMC_TWR_CYC ((`DMC_TWR_NS + `DMC_CLK_PERIOD_NS - 1) / `DMC_CLK_PERIOD_NS)

// ----------------------------------------
// mode register fields and the a10 precharge-all position
// ----------------------------------------
`define DMC_MR_BL_LSB 0
`define DMC_MR_BT_POS 3
`define DMC_MR_CL_LSB 4
`define DMC_MR_TM_POS 7
`define DMC_MR_DLLRST_POS 8
`define DMC_EMR_DLLDIS_POS 0
`define DMC_AP_POS 10

// ----------------------------------------
// command pins {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define DMC_PIN_DESEL 4'h8
`define DMC_PIN_NOP 4'h7
`define DMC_PIN_MRS 4'h0
`define DMC_PIN_PRE 4'h2
`define DMC_PIN_ACT 4'h3
`define DMC_PIN_RD 4'h5
`define DMC_PIN_WR 4'h4

`endif

// [dmc_pkg.sv]
// types shared by the ddr mode/command controller
package dmc_pkg;
   typedef enum logic [2:0] {
      DMC_OP_NOP = 3'h0,
      DMC_OP_MRS = 3'h1,
      DMC_OP_EMRS = 3'h2,
      DMC_OP_PRE = 3'h3,
      DMC_OP_ACT = 3'h4,
      DMC_OP_RD = 3'h5,
      DMC_OP_WR = 3'h6
   } dmc_op_t;

   typedef enum logic [1:0] {
      DMC_ST_IDLE = 2'h0,
      DMC_ST_WAIT = 2'h1
   } dmc_state_t;
endpackage

// [dmc_ctrl_sva.sv]
// assertion checker for the ddr command controller pins
`timescale 1ns/100ps
`default_nettype none
`include "dmc_params.svh"
module dmc_ctrl_sva
   import dmc_pkg::*;
#(
   parameter int ROW_W = 13
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // user side
   input wire logic [2:0] req_op,
   input wire logic [1:0] req_bank,
   input wire logic [ROW_W-1:0] req_addr,
   input wire logic req_all_banks,
   input wire logic req_ready,
   input wire logic req_reject,
   input wire logic [2:0] mode_burst_len,
   input wire logic mode_interleave,
   input wire logic [2:0] mode_cas_lat,
   input wire logic dll_enabled,
   input wire logic [3:0] bank_open,
   // device pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [ROW_W-1:0] addr
);
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire logic mrs = req_ready && cmd == `DMC_PIN_MRS;
   logic [7:0] lock_cnt;
   // ----------------------------------------
   // cycles since dll enable, saturating so long runs never wrap
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         lock_cnt <= 8'h0;
      else if (mrs && ba == 2'h1 && !addr[0])
         lock_cnt <= 8'h0;
      else if (lock_cnt != 8'hff)
         lock_cnt <= lock_cnt + 8'h1;
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_cke_raised: assert property (!$past(rst) |-> cke) else $error("cke low after reset");
   a_cmd_has_req: assert property (cke && !cs_n && cmd != `DMC_PIN_NOP |-> req_ready)
      else $error("command without request");
   a_mode_pins: assert property (req_ready && $past(req_op) == DMC_OP_MRS |-> mrs && !ba[0] && !addr[7])
      else $error("bad mode write pins");
   a_ext_pins: assert property (req_ready && $past(req_op) == DMC_OP_EMRS |-> mrs && ba == 2'h1
      && addr == {{(ROW_W-1){1'b0}}, $past(req_addr[0])}) else $error("bad ext write pins");
   a_mode_gap: assert property (mrs |=> cmd == `DMC_PIN_NOP && !req_ready && !req_reject)
      else $error("command inside mode write");
   a_mode_idle: assert property (mrs |-> $past(bank_open) == 4'h0) else $error("mode write with open bank");
   a_mode_fields: assert property (mrs && !ba[0] |=>
      {mode_cas_lat, mode_interleave, mode_burst_len} == $past(addr[6:0])) else $error("mode copy wrong");
   a_pre_pins: assert property (req_ready && $past(req_op) == DMC_OP_PRE |-> cmd == `DMC_PIN_PRE
      && addr[10] == $past(req_all_banks) && ($past(req_all_banks) || ba == $past(req_bank)))
      else $error("bad precharge pins");
   a_act_pins: assert property (req_ready && $past(req_op) == DMC_OP_ACT |-> cmd == `DMC_PIN_ACT
      && ba == $past(req_bank) && addr == $past(req_addr) && !$past(bank_open[req_bank]))
      else $error("bad activate");
   a_read_gate: assert property (req_ready && $past(req_op) == DMC_OP_RD |-> cmd == `DMC_PIN_RD
      && ba == $past(req_bank) && bank_open[ba] && dll_enabled && lock_cnt >= 8'hc7) else $error("bad read");
   a_write_gate: assert property (req_ready && $past(req_op) == DMC_OP_WR |-> cmd == `DMC_PIN_WR
      && bank_open[ba]) else $error("bad write");
endmodule
bind dmc_ctrl dmc_ctrl_sva #(.ROW_W(ROW_W)) dmc_ctrl_sva_i (.*);
`default_nettype wire

// [dmc_dev_model.sv]
// behavioural ddr device model decoding the controller's command pins
`timescale 1ns/100ps
`default_nettype none
`include "dmc_params.svh"
module dmc_dev_model
#(
   parameter int TRP = 1,
   parameter int TRCD = 1
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // command pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   // observed state
   output logic [12:0] m_mr,
   output logic [3:0] m_open,
   output logic [2:0] m_last,
   output logic [7:0] m_viol
);
   logic [12:0] emr;
   logic [7:0] age [4];
   logic [7:0] dll_age;
   logic busy;
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   // deselect masks all inputs, nop starts nothing
   wire logic live = cke && !cs_n && cmd != `DMC_PIN_NOP;
   wire logic [2:0] blm = m_mr[2:0] == 3'h1 ? 3'h1 : m_mr[2:0] == 3'h2 ? 3'h3 : 3'h7;
   wire logic [2:0] last = m_mr[3] ? addr[2:0] ^ blm : ((addr[2:0] + blm) & blm) | (addr[2:0] & ~blm);
   wire logic pre_done = age[0] >= TRP - 1 && age[1] >= TRP - 1 && age[2] >= TRP - 1 && age[3] >= TRP - 1;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         m_open <= 4'h0;
         m_viol <= 8'h0;
         m_mr <= 13'h0;
         m_last <= 3'h0;
         emr <= 13'h1;
         dll_age <= 8'h0;
         for (int b = 0; b < 4; b++)
            age[b] <= 8'hff;
      end
      else
      begin
         busy <= live && cmd == `DMC_PIN_MRS;
         if (dll_age != 8'hff)
            dll_age <= dll_age + 8'h1;
         for (int b = 0; b < 4; b++)
            if (age[b] != 8'hff)
               age[b] <= age[b] + 8'h1;
         if (live && busy)
            m_viol <= m_viol + 8'h1;
         if (live && cmd == `DMC_PIN_MRS)
         begin
            if (m_open != 4'h0 || !pre_done || (!ba[0] && addr[7]) || (ba[0] && (ba[1] || addr[12:1] != 12'h0)))
               m_viol <= m_viol + 8'h1;
            if (ba[0])
               emr <= {ba[1], addr[11:0]};
            else
               m_mr <= addr;
            if (ba[0] && !addr[0])
               dll_age <= 8'h0;
         end
         if (live && cmd == `DMC_PIN_PRE)
            for (int b = 0; b < 4; b++)
               if (addr[10] || ba == 2'(b))
               begin
                  m_open[b] <= 1'b0;
                  age[b] <= 8'h0;
               end
         if (live && cmd == `DMC_PIN_ACT)
         begin
            if (m_open[ba] || age[ba] < TRP - 1)
               m_viol <= m_viol + 8'h1;
            m_open[ba] <= 1'b1;
            age[ba] <= 8'h0;
         end
         // read needs the dll locked; a write does not
         if (live && (cmd == `DMC_PIN_RD || cmd == `DMC_PIN_WR))
         begin
            if (!m_open[ba] || age[ba] < TRCD - 1 || (cmd == `DMC_PIN_RD && (emr[0] || dll_age < 8'hc7)))
               m_viol <= m_viol + 8'h1;
            m_last <= last;
         end
      end
   end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the ddr command controller against a device model
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dmc_pkg::*;
   logic core_clk, rst, req_valid, req_all_banks;
   logic [2:0] req_op;
   logic [1:0] req_bank;
   logic [12:0] req_addr;
   wire logic req_ready, req_reject, mode_interleave, dll_enabled, cke, cs_n, ras_n, cas_n, we_n;
   wire logic [2:0] mode_burst_len, mode_cas_lat, m_last;
   wire logic [3:0] bank_open, m_open;
   wire logic [1:0] ba;
   wire logic [12:0] addr, m_mr;
   wire logic [7:0] m_viol;
   int error_cnt = 0;
   int n_compared = 0;
   // longer timers than default so refusals show between two requests
   dmc_ctrl #(.TRP_CYC(4), .TRCD_CYC(4), .TWR_CYC(4)) dmc_ctrl_i (.*);
   dmc_dev_model #(.TRP(4), .TRCD(4)) dmc_dev_model_i (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // holds the request n edges, then counts ready and reject pulses
   task automatic send(input logic [2:0] op, input logic [1:0] bk, input logic [12:0] ad, input logic al,
                       input int n, input logic [3:0] e_rdy, input logic [3:0] e_rej);
      logic [3:0] r;
      logic [3:0] j;
      r = 4'h0;
      j = 4'h0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_bank <= bk;
      req_addr <= ad;
      req_all_banks <= al;
      for (int i = 0; i < n; i++)
      begin
         @(posedge core_clk);
         if (i == n - 1)
            req_valid <= 1'b0;
         #1;
         r = r + {3'h0, req_ready};
         j = j + {3'h0, req_reject};
      end
      cmp(r, e_rdy);
      cmp(j, e_rej);
   endtask
   task automatic report_and_stop;
      $display("error_cnt=%0d n_compared=%0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
   initial
   begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_op = 3'h0;
      req_bank = 2'h0;
      req_addr = 13'h0;
      req_all_banks = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      send(DMC_OP_EMRS, 2'h0, 13'h0001, 1'b0, 1, 4'h1, 4'h0);
      cmp(cke, 1'b1);
      cmp(dll_enabled, 1'b0);
      send(DMC_OP_EMRS, 2'h0, 13'h0000, 1'b0, 1, 4'h1, 4'h0);
      cmp(dll_enabled, 1'b1);
      // the middle edge falls in the mode write's second cycle and is ignored
      send(DMC_OP_MRS, 2'h0, 13'h01ab, 1'b0, 3, 4'h2, 4'h0);
      cmp({mode_cas_lat, mode_interleave, mode_burst_len}, 7'h2b);
      cmp(m_mr, 13'h012b);
      send(DMC_OP_ACT, 2'h2, 13'h0abc, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_ACT, 2'h2, 13'h0abc, 1'b0, 1, 4'h0, 4'h1);
      cmp(bank_open, 4'h4);
      send(DMC_OP_MRS, 2'h0, 13'h0022, 1'b0, 1, 4'h0, 4'h1);
      send(DMC_OP_RD, 2'h1, 13'h0000, 1'b0, 1, 4'h0, 4'h1);
      send(DMC_OP_RD, 2'h2, 13'h0001, 1'b0, 1, 4'h0, 4'h1);
      send(DMC_OP_WR, 2'h2, 13'h0004, 1'b0, 1, 4'h1, 4'h0);
      repeat (200) @(posedge core_clk);
      send(DMC_OP_RD, 2'h2, 13'h0001, 1'b0, 1, 4'h1, 4'h0);
      // the model registers the burst one edge after the pins show it
      @(posedge core_clk);
      #1;
      cmp(m_last, 3'h6);
      send(DMC_OP_ACT, 2'h1, 13'h0123, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_RD, 2'h1, 13'h0002, 1'b0, 1, 4'h0, 4'h1);
      repeat (6) @(posedge core_clk);
      send(DMC_OP_RD, 2'h1, 13'h0002, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_WR, 2'h1, 13'h0002, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_PRE, 2'h1, 13'h0000, 1'b0, 1, 4'h0, 4'h1);
      send(DMC_OP_PRE, 2'h2, 13'h0000, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_ACT, 2'h2, 13'h0abc, 1'b0, 1, 4'h0, 4'h1);
      cmp(bank_open, 4'h2);
      send(DMC_OP_PRE, 2'h3, 13'h0000, 1'b1, 1, 4'h1, 4'h0);
      send(DMC_OP_MRS, 2'h0, 13'h0061, 1'b0, 1, 4'h0, 4'h1);
      repeat (6) @(posedge core_clk);
      cmp(bank_open, 4'h0);
      send(DMC_OP_MRS, 2'h0, 13'h0061, 1'b0, 1, 4'h1, 4'h0);
      cmp({mode_cas_lat, mode_interleave, mode_burst_len}, 7'h61);
      send(DMC_OP_ACT, 2'h0, 13'h0000, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_NOP, 2'h0, 13'h0000, 1'b0, 1, 4'h1, 4'h0);
      send(DMC_OP_WR, 2'h0, 13'h0003, 1'b0, 1, 4'h1, 4'h0);
      @(posedge core_clk);
      #1;
      cmp(m_last, 3'h2);
      cmp(m_viol, 8'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
